//--- led_diag_params.svh
`ifndef LED_DIAG_PARAMS_SVH
`define LED_DIAG_PARAMS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_FAULT_FLAGS   8'h12
`define OFS_STATE_MON     8'h14
`define OFS_IN_DUTY_MON   8'h16
`define OFS_OUT_DUTY_MON  8'h18
`define OFS_CURRENT_MON   8'h1A
`define OFS_IRQ_STATUS    8'h20
`define OFS_IRQ_ENABLE    8'h22
`define OFS_IRQ_CLEAR     8'h24

// ----------------------------------------------------------------------------
// fault register field positions
// ----------------------------------------------------------------------------
`define BIT_TIMEOUT_FLAG  14
`define BIT_TIMEOUT_ACK   13
`define BIT_BADCFG_FLAG   12
`define BIT_BADCFG_ACK    11
`define BIT_COMBINED_FLAG 10
`define BIT_COMBINED_ACK  9
`define BIT_GROUND_SHORT  8
`define BIT_INT_SHORT     7
`define BIT_OPEN_STRING   6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_REG16         16'h0000
`define RST_IRQ3          3'h0

`endif

//--- led_diag_pkg.sv
package led_diag_pkg;
  typedef logic [7:0]  addr_t;
  typedef logic [15:0] word_t;
  // live state codes of the functional state machine
  typedef enum logic [4:0] {
    st_disabled        = 5'h00,
    st_regulator_start = 5'h01,
    st_memory_read     = 5'h02,
    st_standby         = 5'h03,
    st_converter_start = 5'h04,
    st_normal          = 5'h10,
    st_shutdown        = 5'h11,
    st_recovery        = 5'h12,
    st_all_failed      = 5'h13
  } live_state_e;
endpackage

//--- led_fault_diag_registers.sv
// Behaviour
// - bit 14 of fault register latches a serial bus timeout fault.
// - writing one to a status bit and its clear bit together clears flag and interrupt.
// - bit 12 latches invalid string configuration; its clear bit is bit 11.
// - bit 10 latches any open, internal short or ground short; clear bit 9.
// - read-only bit 8 shows a string shorted to ground.
// - bits 7 and 6 show internal short and open; cleared with bit 10.
// - bits 5 down to 0 show per-channel faults, channel six on bit 5.
// - state monitor bits 4 to 0 show the live state machine state.
// - state codes 0h to 13h as defined; 4h to Fh mean converter startup.
// - input duty monitor shows the measured 16-bit input duty.
// - output duty monitor shows the configured 16-bit output duty.
// - unused upper bits of diagnostic registers read zero and reset to zero.
// - current monitor bits 11 to 0 hold the 12-bit drive code; upper zero.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "led_diag_params.svh"

module led_fault_diag_registers (
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // register port
  input  wire led_diag_pkg::addr_t  reg_addr_i,
  input  wire led_diag_pkg::word_t  reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic [15:0]               reg_rdata_o,
  // fault events, one-cycle pulses from same-clock logic
  input  wire logic                 bus_timeout_i,
  input  wire logic                 bad_string_cfg_i,
  input  wire logic                 string_fault_i,
  // live fault views
  input  wire logic                 ground_short_i,
  input  wire logic                 internal_short_i,
  input  wire logic                 open_string_i,
  input  wire logic [5:0]           channel_fault_i,
  // live diagnostic values
  input  wire led_diag_pkg::live_state_e live_state_code_i,
  input  wire led_diag_pkg::word_t  input_duty_i,
  input  wire led_diag_pkg::word_t  output_duty_i,
  input  wire logic [11:0]          drive_current_code_i,
  // interrupt
  output logic                      fault_irq_o
);
  import led_diag_pkg::*;

  // ----------------------------------------------------------------------------
  // latched fault flags and sticky detail bits
  // ----------------------------------------------------------------------------
  logic       timeout_flag_ff, nxt_timeout_flag;
  logic       badcfg_flag_ff,  nxt_badcfg_flag;
  logic       combined_flag_ff, nxt_combined_flag;
  logic       int_short_ff,    nxt_int_short;
  logic       open_ff,         nxt_open;
  logic [2:0] irq_en_ff,       nxt_irq_en;
  logic [2:0] irq_sts_ff,      nxt_irq_sts;
  logic [15:0] rdata_ff,       nxt_rdata;

  function automatic logic pair_clear(input logic [15:0] d, input int flag_bit,
                                      input int ack_bit);
    pair_clear = d[flag_bit] & d[ack_bit];
  endfunction

  logic wr_fault;
  logic clr_timeout, clr_badcfg, clr_combined;
  assign wr_fault = reg_wr_i && (reg_addr_i == `OFS_FAULT_FLAGS);
  // paired write decode; a lone one is ignored
  // both bits needed
  assign clr_timeout  = wr_fault && pair_clear(reg_wdata_i, `BIT_TIMEOUT_FLAG, `BIT_TIMEOUT_ACK);
  assign clr_badcfg   = wr_fault && pair_clear(reg_wdata_i, `BIT_BADCFG_FLAG, `BIT_BADCFG_ACK);
  assign clr_combined = wr_fault &&
                        pair_clear(reg_wdata_i, `BIT_COMBINED_FLAG, `BIT_COMBINED_ACK);

  // next flag values; a new event in the clear cycle wins over the clear
  always_comb begin
    nxt_timeout_flag  = bus_timeout_i | (timeout_flag_ff & ~clr_timeout);
    nxt_badcfg_flag   = bad_string_cfg_i | (badcfg_flag_ff & ~clr_badcfg);
    nxt_combined_flag = string_fault_i | ground_short_i | internal_short_i | open_string_i |
                        (combined_flag_ff & ~clr_combined);
    nxt_int_short     = internal_short_i | (int_short_ff & ~clr_combined);
    nxt_open          = open_string_i | (open_ff & ~clr_combined);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_ff  <= 1'b0;
      badcfg_flag_ff   <= 1'b0;
      combined_flag_ff <= 1'b0;
      int_short_ff     <= 1'b0;
      open_ff          <= 1'b0;
    end else begin
      timeout_flag_ff  <= nxt_timeout_flag;
      badcfg_flag_ff   <= nxt_badcfg_flag;
      combined_flag_ff <= nxt_combined_flag;
      int_short_ff     <= nxt_int_short;
      open_ff          <= nxt_open;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt status, enable and clear
  // ----------------------------------------------------------------------------
  logic [2:0] irq_events;
  logic [2:0] pair_clr;
  assign irq_events = {nxt_combined_flag & ~combined_flag_ff,
                       nxt_badcfg_flag & ~badcfg_flag_ff,
                       nxt_timeout_flag & ~timeout_flag_ff};
  assign pair_clr   = {clr_combined, clr_badcfg, clr_timeout};

  // status may only drop once the fault itself is acknowledged, so the pin
  // cannot fall while a fault flag stands latched with its enable bit set
  always_comb begin
    nxt_irq_en  = irq_en_ff;
    nxt_irq_sts = irq_sts_ff;
    if (reg_wr_i && (reg_addr_i == `OFS_IRQ_ENABLE)) begin
      nxt_irq_en = reg_wdata_i[2:0];
    end
    if (reg_wr_i && (reg_addr_i == `OFS_IRQ_CLEAR)) begin
      nxt_irq_sts = nxt_irq_sts & ~(reg_wdata_i[2:0] &
                    ~{combined_flag_ff, badcfg_flag_ff, timeout_flag_ff});
    end
    nxt_irq_sts = (nxt_irq_sts & ~pair_clr) | irq_events |
                  {nxt_combined_flag, nxt_badcfg_flag, nxt_timeout_flag};
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_ff  <= `RST_IRQ3;
      irq_sts_ff <= `RST_IRQ3;
    end else begin
      irq_en_ff  <= nxt_irq_en;
      irq_sts_ff <= nxt_irq_sts;
    end
  end

  // level interrupt while an enabled status bit stands
  assign fault_irq_o = |(irq_sts_ff & irq_en_ff);

  // ----------------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------------
  logic [15:0] fault_word;
  always_comb begin
    fault_word = `RST_REG16;
    fault_word[`BIT_TIMEOUT_FLAG]  = timeout_flag_ff;
    fault_word[`BIT_BADCFG_FLAG]   = badcfg_flag_ff;
    fault_word[`BIT_COMBINED_FLAG] = combined_flag_ff;
    fault_word[`BIT_GROUND_SHORT]  = ground_short_i;
    fault_word[`BIT_INT_SHORT]     = int_short_ff;
    fault_word[`BIT_OPEN_STRING]   = open_ff;
    fault_word[5:0]                = channel_fault_i;
  end

  // read data registered; unmapped addresses read zero
  always_comb begin
    nxt_rdata = `RST_REG16;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OFS_FAULT_FLAGS:  nxt_rdata = fault_word;
        // live state code passed through, upper bits zero
        `OFS_STATE_MON:    nxt_rdata = {11'h000, live_state_code_i};
        `OFS_IN_DUTY_MON:  nxt_rdata = input_duty_i;
        `OFS_OUT_DUTY_MON: nxt_rdata = output_duty_i;
        `OFS_CURRENT_MON:  nxt_rdata = {4'h0, drive_current_code_i};
        `OFS_IRQ_STATUS:   nxt_rdata = {13'h0000, irq_sts_ff};
        `OFS_IRQ_ENABLE:   nxt_rdata = {13'h0000, irq_en_ff};
        default:           nxt_rdata = `RST_REG16;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= `RST_REG16;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata_o = rdata_ff;

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  // steps of a paired clear: the write, with no fresh event beside it
  sequence s_timeout_pair;
    clr_timeout && !bus_timeout_i;
  endsequence
  sequence s_badcfg_pair;
    clr_badcfg && !bad_string_cfg_i;
  endsequence
  // any live string input sets the flag again, so none may stand here
  sequence s_combined_pair;
    clr_combined && !string_fault_i && !ground_short_i &&
    !internal_short_i && !open_string_i;
  endsequence
  // a lone ack bit of the config pair while its flag stands
  sequence s_badcfg_lone_ack;
    wr_fault && !reg_wdata_i[`BIT_BADCFG_FLAG] && reg_wdata_i[`BIT_BADCFG_ACK] &&
    badcfg_flag_ff;
  endsequence

  a_timeout_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bus_timeout_i |=> timeout_flag_ff)
    else $error("timeout flag not set");

  a_timeout_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_timeout_pair |=> !timeout_flag_ff && !irq_sts_ff[0])
    else $error("timeout pair clear failed");

  a_pair_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_badcfg_pair |=> !badcfg_flag_ff && !irq_sts_ff[1])
    else $error("paired clear failed");

  a_badcfg_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    bad_string_cfg_i |=> badcfg_flag_ff)
    else $error("bad config flag not set");

  a_combined_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    open_string_i || ground_short_i |=> combined_flag_ff)
    else $error("combined flag not set");

  a_string_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    string_fault_i || internal_short_i |=> combined_flag_ff)
    else $error("combined flag missed a string event");

  a_ground_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_FAULT_FLAGS
    |=> reg_rdata_o[8] == $past(ground_short_i))
    else $error("ground short bit wrong");

  a_short_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    internal_short_i |=> int_short_ff)
    else $error("internal short bit not set");

  a_open_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    open_string_i |=> open_ff)
    else $error("open string bit not set");

  a_combined_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_combined_pair |=> !combined_flag_ff && !int_short_ff && !open_ff)
    else $error("combined pair clear left a bit set");

  a_channel_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_FAULT_FLAGS
    |=> reg_rdata_o[5:0] == $past(channel_fault_i))
    else $error("channel fault bits wrong");

  a_state_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_STATE_MON
    |=> reg_rdata_o[4:0] == $past(live_state_code_i))
    else $error("state code read wrong");

  a_state_codes: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_STATE_MON |=> reg_rdata_o[15:5] == 11'h000)
    else $error("state monitor upper bits not zero");

  a_duty_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_IN_DUTY_MON |=> reg_rdata_o == $past(input_duty_i))
    else $error("input duty read wrong");

  a_out_duty_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_OUT_DUTY_MON |=> reg_rdata_o == $past(output_duty_i))
    else $error("output duty read wrong");

  a_current_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    reg_rd_i && reg_addr_i == `OFS_CURRENT_MON
    |=> reg_rdata_o == {4'h0, $past(drive_current_code_i)})
    else $error("current monitor read wrong");

  a_irq_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    timeout_flag_ff && irq_en_ff[0] |-> fault_irq_o)
    else $error("interrupt dropped with fault latched");

  a_badcfg_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    badcfg_flag_ff && !clr_badcfg |=> badcfg_flag_ff)
    else $error("config flag dropped without paired clear");

  a_lone_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_fault && reg_wdata_i[`BIT_TIMEOUT_FLAG] && !reg_wdata_i[`BIT_TIMEOUT_ACK]
    && timeout_flag_ff |=> timeout_flag_ff)
    else $error("lone write cleared fault");

  a_lone_ack: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_badcfg_lone_ack |=> badcfg_flag_ff)
    else $error("lone ack write cleared fault");

endmodule

`default_nettype wire

//--- led_diag_host.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------------------
// host model driving the register port
// ----------------------------------------------------------------------------
module led_diag_host (
  // clock
  input  wire logic               sys_clk_i,
  // register port
  output var led_diag_pkg::addr_t reg_addr_o,
  output var led_diag_pkg::word_t reg_wdata_o,
  output logic                    reg_wr_o,
  output logic                    reg_rd_o,
  input  wire logic [15:0]        reg_rdata_i
);
  import led_diag_pkg::*;
  // idle bus from time zero
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 16'h0000;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
  end
  // one-cycle write; released lines show inverted data so stale values never match
  task automatic write_reg(input addr_t a, input word_t d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_o <= 1'b0;
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask
  // one-cycle read, data taken in the following cycle only
  task automatic read_reg(input addr_t a, output word_t d);
    @(posedge sys_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    @(negedge sys_clk_i);
    d = reg_rdata_i;
  endtask
  task automatic clear_pair(input int flag);
    write_reg(8'h12, (16'h0001 << flag) | (16'h0001 << (flag - 1)));
  endtask
endmodule
`default_nettype wire

//--- test_led_fault_diag_registers.sv
`timescale 1ns/1ns
`default_nettype none
module test_led_fault_diag_registers;
  import led_diag_pkg::*;
  logic        sys_clk_i, rst_i, ground_short_i, fault_irq_o, reg_wr_i, reg_rd_i;
  logic [4:0]  ev;
  logic [5:0]  channel_fault_i, chan;
  logic [11:0] drive_current_code_i;
  logic [15:0] reg_rdata_o;
  live_state_e live_state_code_i;
  addr_t       reg_addr_i;
  word_t       reg_wdata_i, input_duty_i, output_duty_i, rd;
  int          num_errors, n_compared, cycles;
  // ----------------------------------------------------------------------------
  // design and host
  // ----------------------------------------------------------------------------
  led_fault_diag_registers u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .bus_timeout_i(ev[0]),
    .bad_string_cfg_i(ev[1]), .string_fault_i(ev[2]), .ground_short_i(ground_short_i),
    .internal_short_i(ev[3]), .open_string_i(ev[4]), .channel_fault_i(channel_fault_i),
    .live_state_code_i(live_state_code_i), .input_duty_i(input_duty_i),
    .output_duty_i(output_duty_i), .drive_current_code_i(drive_current_code_i),
    .fault_irq_o(fault_irq_o));
  led_diag_host u_host (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_rdata_i(reg_rdata_o));
  // 125 MHz clock
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] expv);
    n_compared++;
    if (seen !== expv) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic rd_chk(input addr_t a, input word_t e);
    u_host.read_reg(a, rd);
    check(rd, e);
  endtask
  task automatic irq_chk(input logic e);
    @(negedge sys_clk_i);
    check({15'h0000, fault_irq_o}, {15'h0000, e});
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // latched word expected after event k
  function automatic word_t exp_fault(input int k);
    case (k)
      0: return 16'h4000;
      1: return 16'h1000;
      3: return 16'h0480;
      4: return 16'h0440;
      default: return 16'h0400;
    endcase
  endfunction
  function automatic int flag_of(input int k);
    return (k == 0) ? 14 : (k == 1) ? 12 : 10;
  endfunction
  initial begin
    void'($urandom(39081));
    rst_i = 1'b1;
    ev = 5'h00;
    ground_short_i = 1'b0;
    channel_fault_i = 6'h00;
    drive_current_code_i = 12'h000;
    live_state_code_i = st_disabled;
    input_duty_i = 16'h0000;
    output_duty_i = 16'h0000;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // every register but the clear register at 24h, and the unmapped gaps, read zero after reset
    for (int i = 0; i < 9; i++) rd_chk(8'h12 + 8'(2 * i), 16'h0000);
    $display("test reset done");
    // every state code, random duty and current values
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk_i);
      live_state_code_i <= live_state_e'(5'(i));
      input_duty_i <= word_t'($urandom);
      output_duty_i <= word_t'($urandom);
      drive_current_code_i <= 12'($urandom);
      rd_chk(8'h14, {11'h000, 5'(i)});
      rd_chk(8'h16, input_duty_i);
      rd_chk(8'h18, output_duty_i);
      rd_chk(8'h1A, {4'h0, drive_current_code_i});
    end
    // read-only and unmapped places ignore writes
    u_host.write_reg(8'h14, 16'hFFFF);
    u_host.write_reg(8'h30, 16'hFFFF);
    rd_chk(8'h14, 16'h0013);
    rd_chk(8'h30, 16'h0000);
    $display("test monitors done");
    // each event: masked, enabled, half-pair writes, then the paired clear
    for (int k = 0; k < 5; k++) begin
      @(posedge sys_clk_i);
      ev <= 5'h01 << k;
      @(posedge sys_clk_i);
      ev <= 5'h00;
      rd_chk(8'h12, exp_fault(k));
      rd_chk(8'h20, (k < 2) ? 16'(k + 1) : 16'h0004);
      irq_chk(1'b0);
      u_host.write_reg(8'h22, 16'h0007);
      irq_chk(1'b1);
      u_host.write_reg(8'h12, 16'h0001 << flag_of(k));
      u_host.write_reg(8'h12, 16'h0001 << (flag_of(k) - 1));
      u_host.write_reg(8'h24, 16'h0007);
      rd_chk(8'h12, exp_fault(k));
      irq_chk(1'b1);
      u_host.clear_pair(flag_of(k));
      rd_chk(8'h12, 16'h0000);
      irq_chk(1'b0);
      u_host.write_reg(8'h22, 16'h0000);
    end
    $display("test fault pairs done");
    // a reset in mid-run drops a latched fault, the enables and the pin
    @(posedge sys_clk_i);
    ev <= 5'h02;
    @(posedge sys_clk_i);
    ev <= 5'h00;
    u_host.write_reg(8'h22, 16'h0007);
    irq_chk(1'b1);
    rd_chk(8'h22, 16'h0007);
    @(posedge sys_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    irq_chk(1'b0);
    rd_chk(8'h12, 16'h0000);
    rd_chk(8'h20, 16'h0000);
    rd_chk(8'h22, 16'h0000);
    $display("test mid-run reset done");
    // live channel bits, all six first, then a ground short that latches the combined flag
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk_i);
      chan = (i == 0) ? 6'h3F : 6'($urandom);
      channel_fault_i <= chan;
      rd_chk(8'h12, {10'h000, chan});
    end
    @(posedge sys_clk_i);
    ground_short_i <= 1'b1;
    channel_fault_i <= 6'h21;
    rd_chk(8'h12, 16'h0521);
    @(posedge sys_clk_i);
    ground_short_i <= 1'b0;
    channel_fault_i <= 6'h00;
    rd_chk(8'h12, 16'h0400);
    u_host.clear_pair(10);
    rd_chk(8'h12, 16'h0000);
    $display("test live views done");
    end_of_test();
  end
endmodule
`default_nettype wire
